// ===== etc_pkg.sv
// package of register map, field positions, codes and state for the capture timer core
`default_nettype none
package etc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // register byte addresses on the apb bus
    localparam logic [7:0] ADDR_CTRL_ZERO = 8'h00;
    localparam logic [7:0] ADDR_CTRL_ONE = 8'h04;
    localparam logic [7:0] ADDR_CTRL_TWO = 8'h08;
    localparam logic [7:0] ADDR_CNT_LO = 8'h0C;
    localparam logic [7:0] ADDR_CNT_HI = 8'h10;
    localparam logic [7:0] ADDR_CMPA_LO = 8'h14;
    localparam logic [7:0] ADDR_CMPA_HI = 8'h18;
    localparam logic [7:0] ADDR_CMPB_LO = 8'h1C;
    localparam logic [7:0] ADDR_CMPB_HI = 8'h20;
    localparam logic [7:0] ADDR_STATUS = 8'h24;

    ////////////////////////////////////////////////////////////////////////////
    // timer_control_zero fields
    localparam int PAUSE_BIT = 7;
    localparam int CLK_SEL_MSB = 6;
    localparam int CLK_SEL_LSB = 4;
    localparam int ON_BIT = 3;
    localparam int PERIOD_MSB = 2;
    localparam int PERIOD_LSB = 0;

    // timer_control_one fields
    localparam int OP_SEL_MSB = 7;
    localparam int OP_SEL_LSB = 6;
    localparam int PIN_FN_MSB = 5;
    localparam int PIN_FN_LSB = 4;
    localparam int DIR_BIT = 1;
    localparam int CLR_SRC_BIT = 0;
    // direction flag is read only and stays at count-up
    localparam logic [7:0] CTRL_ONE_WMASK = 8'hFD;

    // status flag positions, write one to clear
    localparam int FLAG_CAPTURE = 0;
    localparam int FLAG_PERIOD = 1;
    localparam int FLAG_MATCH_A = 2;
    localparam int FLAG_MATCH_B = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [9:0] VALUE_RST = 10'h000;
    localparam logic [3:0] FLAGS_RST = 4'h0;
    localparam logic [5:0] DIV_RST = 6'h00;

    ////////////////////////////////////////////////////////////////////////////
    // codes
    localparam logic [1:0] MODE_CAPTURE = 2'h1;
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam logic [1:0] EDGE_BOTH = 2'h2;
    localparam logic [2:0] CK_SYS_DIV4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_HIGH_DIV16 = 3'h2;
    localparam logic [2:0] CK_HIGH_DIV64 = 3'h3;
    localparam logic [2:0] CK_TIME_BASE = 3'h4;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;
    localparam logic [6:0] PERIOD_STEP_LAST = 7'h7F;
    localparam int NUM_PINS = 3;

    ////////////////////////////////////////////////////////////////////////////
    // whole state of the core
    typedef struct packed {
        logic [7:0] ctrl_zero;
        logic [7:0] ctrl_one;
        logic [7:0] ctrl_two;
        logic [9:0] cnt;
        logic [9:0] cmpa;
        logic [9:0] cmpb;
        logic [3:0] flags;
        logic prev_on;
        logic [5:0] div;
        logic ext_prev;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] pin_prev;
        logic [31:0] rdata;
        logic slverr;
    } etc_state_s;

endpackage
`default_nettype wire

// ===== etc_core.sv
// capture timer core: 10-bit counter, three comparators, capture input mode, apb registers
//
// Contract
// - capture operation is selected by op select field value 01
// - capture edge selects rising, falling or both via pin function bits
// - counter starts when counter on bit rises in capture operation
// - selected pin edge copies count into compare A and raises request
// - pin activity never stops or reloads counter; runs until on bit falls
// - period match resets counter to zero, limiting the maximum count
// - period match in capture operation also raises a request
// - pin function 11 disables all capture while counter keeps running
// - transitions of a pin driven as output may still capture
// - clear source select and duty period swap ignored in capture operation
// - capture drives no timer output; level and polarity bits unused
// - period value zero lets the counter run its full range
// - 10-bit counter clocked from selectable internal or external source
// - three comparators A, B and period compare the counter
// - period compares three bits to top counter bits; A and B all bits
// - software changes counter only by clearing via on bit rising
// - counter clears on overflow or comparator match, raising a request
// - counter read as low byte and two-bit high register
// - compare A and B held in read/write low and high registers
// - unimplemented high register bits read as zero
// - clock select codes pick divided system, time base or pin edges
// - pause bit freezes counter, clearing resumes from held value
// - on bit low stops and holds counter; rising edge clears it
// - period codes give 128 to 896 clocks, code zero gives 1024
//
// The APB slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module etc_core (
    // clock and reset
    input wire logic I_MCLK,
    input wire logic I_SRST,
    // apb slave
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [7:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    input wire logic [3:0] I_PSTRB,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    // counting sources
    input wire logic I_TIME_BASE_TICK,
    input wire logic I_EXT_COUNT_CLOCK_PIN,
    // capture pins
    input wire logic I_CAPTURE_PIN_ZERO,
    input wire logic I_CAPTURE_PIN_ONE,
    input wire logic I_CAPTURE_PIN_TWO,
    // status
    output logic O_CAPTURE_FLAG,
    output logic O_PERIOD_FLAG,
    output logic [9:0] O_COUNTER_VALUE
);

    ////////////////////////////////////////////////////////////////////////////
    // state and decoded controls
    etc_pkg::etc_state_s s;
    etc_pkg::etc_state_s next_s;

    logic on_bit;
    logic pause_bit;
    logic [2:0] clk_sel;
    logic [2:0] period_code;
    logic [1:0] op_select;
    logic [1:0] pin_function;
    logic clear_source_select;
    logic cap_mode;
    logic tick;
    logic [9:0] period_last;
    logic period_hit;
    logic match_a_hit;
    logic match_b_hit;
    logic wrap;
    logic on_rise;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;
    logic [2:0] pin_sel;
    logic cap_evt;
    logic [2:0] pins;
    logic wr_en;
    logic rd_setup;
    logic addr_hit;
    logic [31:0] rd_mux;

    assign on_bit = s.ctrl_zero[etc_pkg::ON_BIT];
    assign pause_bit = s.ctrl_zero[etc_pkg::PAUSE_BIT];
    assign clk_sel = s.ctrl_zero[etc_pkg::CLK_SEL_MSB:etc_pkg::CLK_SEL_LSB];
    assign period_code = s.ctrl_zero[etc_pkg::PERIOD_MSB:etc_pkg::PERIOD_LSB];
    assign op_select = s.ctrl_one[etc_pkg::OP_SEL_MSB:etc_pkg::OP_SEL_LSB];
    assign pin_function = s.ctrl_one[etc_pkg::PIN_FN_MSB:etc_pkg::PIN_FN_LSB];
    assign clear_source_select = s.ctrl_one[etc_pkg::CLR_SRC_BIT];
    assign cap_mode = (op_select == etc_pkg::MODE_CAPTURE);
    assign on_rise = on_bit && !s.prev_on;

    ////////////////////////////////////////////////////////////////////////////
    // counter clock enable from the selected source
    always_comb begin
        case (clk_sel)
            etc_pkg::CK_SYS_DIV4: tick = (s.div[1:0] == 2'h3);
            etc_pkg::CK_SYS: tick = 1'b1;
            etc_pkg::CK_HIGH_DIV16: tick = (s.div[3:0] == 4'hF);
            etc_pkg::CK_HIGH_DIV64: tick = (s.div == 6'h3F);
            etc_pkg::CK_TIME_BASE: tick = I_TIME_BASE_TICK;
            etc_pkg::CK_EXT_RISE: tick = I_EXT_COUNT_CLOCK_PIN && !s.ext_prev;
            etc_pkg::CK_EXT_FALL: tick = !I_EXT_COUNT_CLOCK_PIN && s.ext_prev;
            default: tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // comparators
    // last count before the period match; code zero wraps at the top value
    assign period_last = {period_code - 3'h1, etc_pkg::PERIOD_STEP_LAST};
    assign period_hit = (s.cnt == period_last);
    assign match_a_hit = (s.cnt == s.cmpa);
    assign match_b_hit = (s.cnt == s.cmpb);
    // capture operation always clears on the period match
    assign wrap = (cap_mode || !clear_source_select) ? period_hit : match_a_hit;

    ////////////////////////////////////////////////////////////////////////////
    // capture pin edge detection, from the second synchroniser stage onward
    assign pins = {I_CAPTURE_PIN_TWO, I_CAPTURE_PIN_ONE, I_CAPTURE_PIN_ZERO};

    genvar gi;
    generate
        for (gi = 0; gi < etc_pkg::NUM_PINS; gi++) begin : g_pin
            assign pin_rise[gi] = s.sync2[gi] && !s.pin_prev[gi];
            assign pin_fall[gi] = !s.sync2[gi] && s.pin_prev[gi];
            always_comb begin
                case (pin_function)
                    etc_pkg::EDGE_RISE: pin_sel[gi] = pin_rise[gi];
                    etc_pkg::EDGE_FALL: pin_sel[gi] = pin_fall[gi];
                    etc_pkg::EDGE_BOTH: pin_sel[gi] = pin_rise[gi] || pin_fall[gi];
                    default: pin_sel[gi] = 1'b0;
                endcase
            end
        end
    endgenerate

    // a selected edge on any pin counts, whoever drives the pin
    assign cap_evt = cap_mode && (|pin_sel);

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    assign wr_en = I_PSEL && I_PENABLE && I_PWRITE && I_PSTRB[0];
    assign rd_setup = I_PSEL && !I_PENABLE;

    always_comb begin
        addr_hit = 1'b1;
        case (I_PADDR)
            etc_pkg::ADDR_CTRL_ZERO: rd_mux = 32'(s.ctrl_zero);
            etc_pkg::ADDR_CTRL_ONE: rd_mux = 32'(s.ctrl_one);
            etc_pkg::ADDR_CTRL_TWO: rd_mux = 32'(s.ctrl_two);
            etc_pkg::ADDR_CNT_LO: rd_mux = 32'(s.cnt[7:0]);
            etc_pkg::ADDR_CNT_HI: rd_mux = 32'(s.cnt[9:8]);
            etc_pkg::ADDR_CMPA_LO: rd_mux = 32'(s.cmpa[7:0]);
            etc_pkg::ADDR_CMPA_HI: rd_mux = 32'(s.cmpa[9:8]);
            etc_pkg::ADDR_CMPB_LO: rd_mux = 32'(s.cmpb[7:0]);
            etc_pkg::ADDR_CMPB_HI: rd_mux = 32'(s.cmpb[9:8]);
            etc_pkg::ADDR_STATUS: rd_mux = 32'(s.flags);
            default: begin
                rd_mux = 32'h0000_0000;
                addr_hit = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        next_s = s;
        next_s.div = s.div + 6'h01;
        next_s.ext_prev = I_EXT_COUNT_CLOCK_PIN;
        next_s.sync1 = pins;
        next_s.sync2 = s.sync1;
        next_s.pin_prev = s.sync2;
        next_s.prev_on = on_bit;

        // register reads are prepared in the setup phase
        if (rd_setup) begin
            next_s.rdata = I_PWRITE ? 32'h0000_0000 : rd_mux;
            next_s.slverr = !addr_hit;
        end

        // software writes; the counter has no write path
        if (wr_en) begin
            case (I_PADDR)
                etc_pkg::ADDR_CTRL_ZERO: next_s.ctrl_zero = I_PWDATA[7:0];
                etc_pkg::ADDR_CTRL_ONE: next_s.ctrl_one = I_PWDATA[7:0] & etc_pkg::CTRL_ONE_WMASK;
                etc_pkg::ADDR_CTRL_TWO: next_s.ctrl_two = I_PWDATA[7:0];
                etc_pkg::ADDR_CMPA_LO: next_s.cmpa[7:0] = I_PWDATA[7:0];
                etc_pkg::ADDR_CMPA_HI: next_s.cmpa[9:8] = I_PWDATA[1:0];
                etc_pkg::ADDR_CMPB_LO: next_s.cmpb[7:0] = I_PWDATA[7:0];
                etc_pkg::ADDR_CMPB_HI: next_s.cmpb[9:8] = I_PWDATA[1:0];
                etc_pkg::ADDR_STATUS: next_s.flags = s.flags & ~I_PWDATA[3:0];
                default: next_s.flags = next_s.flags;
            endcase
        end

        // counter: cleared on on-bit rise, held while off or paused
        if (on_rise) begin
            next_s.cnt = etc_pkg::VALUE_RST;
        end else if (on_bit && !pause_bit && tick) begin
            if (wrap) begin
                next_s.cnt = etc_pkg::VALUE_RST;
            end else begin
                next_s.cnt = s.cnt + 10'h001;
            end
            // flags set after the software clear so a same-cycle event wins
            if (period_hit && (cap_mode || !clear_source_select)) begin
                next_s.flags[etc_pkg::FLAG_PERIOD] = 1'b1;
            end
            if (match_a_hit && !cap_mode) begin
                next_s.flags[etc_pkg::FLAG_MATCH_A] = 1'b1;
            end
            if (match_b_hit) begin
                next_s.flags[etc_pkg::FLAG_MATCH_B] = 1'b1;
            end
        end

        // capture wins over a software write to compare A in the same cycle
        if (cap_evt) begin
            next_s.cmpa = s.cnt;
            next_s.flags[etc_pkg::FLAG_CAPTURE] = 1'b1;
        end
    end

    always_ff @(posedge I_MCLK) begin
        if (I_SRST) begin
            s <= '{ctrl_zero: etc_pkg::CTRL_RST, ctrl_one: etc_pkg::CTRL_RST,
                   ctrl_two: etc_pkg::CTRL_RST, cnt: etc_pkg::VALUE_RST,
                   cmpa: etc_pkg::VALUE_RST, cmpb: etc_pkg::VALUE_RST,
                   flags: etc_pkg::FLAGS_RST, prev_on: 1'b0, div: etc_pkg::DIV_RST,
                   ext_prev: 1'b0, sync1: 3'h0, sync2: 3'h0, pin_prev: 3'h0,
                   rdata: 32'h0000_0000, slverr: 1'b0};
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs; capture drives no timer pin at all
    assign O_PRDATA = s.rdata;
    assign O_PREADY = 1'b1;
    assign O_PSLVERR = s.slverr && I_PSEL && I_PENABLE;
    assign O_CAPTURE_FLAG = s.flags[etc_pkg::FLAG_CAPTURE];
    assign O_PERIOD_FLAG = s.flags[etc_pkg::FLAG_PERIOD];
    assign O_COUNTER_VALUE = s.cnt;

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge I_MCLK); endclocking
    default disable iff (I_SRST);

    sequence on_rise_s;
        on_bit && !s.prev_on;
    endsequence

    sequence counting_s;
        on_bit && s.prev_on && !pause_bit && tick;
    endsequence

    sequence period_step_s;
        counting_s ##0 (cap_mode && period_hit);
    endsequence

    on_rise_clear_a: assert property (on_rise_s |=> s.cnt == 10'h000)
        else $error("counter not cleared after on bit rise");

    off_hold_a: assert property ((!on_bit) ##1 (!on_bit) |-> $stable(s.cnt))
        else $error("counter moved while off");

    pause_freeze_a: assert property (on_bit && s.prev_on && pause_bit |=> s.cnt == $past(s.cnt))
        else $error("counter moved while paused");

    count_step_a: assert property (counting_s ##0 !wrap |=> s.cnt == $past(s.cnt) + 10'h001)
        else $error("counter did not step by one");

    period_wrap_a: assert property (period_step_s |=> (s.cnt == 10'h000) && s.flags[1])
        else $error("period match did not clear counter and set flag");

    full_range_a: assert property (counting_s ##0 (cap_mode && period_code == 3'h0 && s.cnt == 10'h3FF)
        |=> s.cnt == 10'h000)
        else $error("full range wrap missed");

    no_early_wrap_a: assert property (counting_s ##0 (cap_mode && period_code == 3'h4 && s.cnt == 10'h1FE)
        |=> s.cnt == 10'h1FF)
        else $error("period code four wrapped early");

    capture_copy_a: assert property (cap_evt |=> s.cmpa == $past(s.cnt) && s.flags[0])
        else $error("capture did not copy count or set flag");

    capture_off_a: assert property (cap_mode && pin_function == 2'h3 |-> !cap_evt)
        else $error("capture while disabled");

    // a capture with no further pin change behind it must not repeat
    pin_once_a: assert property (cap_evt ##1 ($past(pins, 2) == $past(pins, 3)) |-> !cap_evt)
        else $error("one pin edge captured twice");

    hi_zero_a: assert property (I_PSEL && I_PENABLE && !I_PWRITE && I_PADDR == etc_pkg::ADDR_CNT_HI
        |-> O_PRDATA[31:2] == 30'h0000_0000)
        else $error("upper bits of high register not zero");

endmodule // etc_core
`default_nettype wire

// ===== etc_pulse_src.sv
// partner model: pulse sources on the capture pins and the count clock pin
`timescale 1ns/1ps
`default_nettype none
module etc_pulse_src (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // command: invert the level of one source
    input wire logic i_flip,
    input wire logic [1:0] i_which,
    // pins
    output logic o_pin_zero,
    output logic o_pin_one,
    output logic o_pin_two,
    output logic o_ext_clk
);
    logic [3:0] lvl;
    // a level is held for a cycle at least, so each edge stands alone
    always_ff @(posedge i_clk) begin
        if (i_srst) begin
            lvl <= 4'h0;
        end else if (i_flip) begin
            lvl[i_which] <= ~lvl[i_which];
        end
    end
    assign {o_ext_clk, o_pin_two, o_pin_one, o_pin_zero} = lvl;
endmodule // etc_pulse_src
`default_nettype wire

// ===== enhanced_timer_capture_core_tb_top.sv
// self-checking bench for the capture timer core
`timescale 1ns/1ps
`default_nettype none
module enhanced_timer_capture_core_tb_top;
    logic clk, srst, psel, penable, pwrite, tbt, fl, pready, pslverr, cap_f, per_f, p0, p1, p2, ext;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [9:0] cnt;
    logic [1:0] which;
    int failures = 0;
    int comparisons = 0;

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    etc_core etc_core_inst (.I_MCLK(clk), .I_SRST(srst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(4'hF), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_TIME_BASE_TICK(tbt), .I_EXT_COUNT_CLOCK_PIN(ext),
        .I_CAPTURE_PIN_ZERO(p0), .I_CAPTURE_PIN_ONE(p1), .I_CAPTURE_PIN_TWO(p2),
        .O_CAPTURE_FLAG(cap_f), .O_PERIOD_FLAG(per_f), .O_COUNTER_VALUE(cnt));

    etc_pulse_src etc_pulse_src_inst (.i_clk(clk), .i_srst(srst), .i_flip(fl), .i_which(which),
        .o_pin_zero(p0), .o_pin_one(p1), .o_pin_two(p2), .o_ext_clk(ext));

    ////////////////////////////////////////////////////////////////////////////
    task automatic results();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("BAD at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_rng(input logic [9:0] got, input logic [9:0] lo, input logic [9:0] hi);
        comparisons++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            failures++;
            $display("BAD at %0t got %h exp %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d,
                       output logic [7:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata[7:0];
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            failures++;
            results();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] r);
        logic e;
        apb(1'b0, a, 8'h00, r, e);
    endtask

    task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
        logic [7:0] r;
        wr(a, d);
        rd(a, r);
        check(10'(r), 10'(exp));
    endtask

    task automatic pin_flip(input logic [1:0] w);
        @(posedge clk);
        fl <= 1'b1;
        which <= w;
        @(posedge clk);
        fl <= 1'b0;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic restart(input logic [2:0] s);
        wr(etc_pkg::ADDR_CTRL_ZERO, {1'b0, s, 4'h0});
        wr(etc_pkg::ADDR_CTRL_ZERO, {1'b0, s, 4'h8});
    endtask

    task automatic wait_per(input int bound, output logic [9:0] mx);
        int n;
        n = 0;
        mx = 10'h000;
        while (per_f !== 1'b1 && n < bound) begin
            @(posedge clk);
            if (cnt > mx) begin
                mx = cnt;
            end
            n++;
        end
        if (n >= bound) begin
            failures++;
            results();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [7:0] r;
        logic e;
        for (int a = 0; a <= 32; a += 4) begin
            apb(1'b0, 8'(a), 8'h00, r, e);
            check(10'(r), 10'h000);
            check(10'(e), 10'h000);
        end
        apb(1'b0, 8'h28, 8'h00, r, e);
        check(10'(e), 10'h001);
        wrd(etc_pkg::ADDR_CNT_LO, 8'hFF, 8'h00);
        wrd(etc_pkg::ADDR_CMPA_HI, 8'hFF, 8'h03);
        wrd(etc_pkg::ADDR_CMPB_LO, 8'hA5, 8'hA5);
        wrd(etc_pkg::ADDR_CMPB_HI, 8'hFF, 8'h03);
        wrd(etc_pkg::ADDR_CTRL_ONE, 8'hFF, 8'hFD);
        wr(etc_pkg::ADDR_CTRL_ONE, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_period();
        logic [9:0] mx;
        // capture mode, pin capture off, clear source set
        wr(etc_pkg::ADDR_CTRL_ONE, 8'h71);
        wr(etc_pkg::ADDR_CTRL_ZERO, 8'h19);
        wait_per(400, mx);
        check(mx, 10'h07F);
        check(10'(per_f), 10'h001);
        check(10'(cap_f), 10'h000);
        wr(etc_pkg::ADDR_STATUS, 8'h0F);
        wr(etc_pkg::ADDR_CTRL_ZERO, 8'h18);
        wait_per(1200, mx);
        check(mx, 10'h3FF);
        wr(etc_pkg::ADDR_STATUS, 8'h0F);
        wr(etc_pkg::ADDR_CTRL_ZERO, 8'h1C);
        wait_per(700, mx);
        check(mx, 10'h1FF);
        $display("test period done");
    endtask

    task automatic t_pause();
        logic [9:0] v;
        logic [7:0] l, h;
        tick(100);
        wr(etc_pkg::ADDR_CTRL_ZERO, 8'h98);
        tick(3);
        v = cnt;
        tick(20);
        check(cnt, v);
        wr(etc_pkg::ADDR_CTRL_ZERO, 8'h18);
        tick(10);
        check_rng(cnt, v + 10'd1, v + 10'd14);
        wr(etc_pkg::ADDR_CTRL_ZERO, 8'h10);
        tick(3);
        v = cnt;
        tick(20);
        check(cnt, v);
        rd(etc_pkg::ADDR_CNT_LO, l);
        rd(etc_pkg::ADDR_CNT_HI, h);
        check({h[1:0], l}, v);
        check(10'(h[7:2]), 10'h000);
        wr(etc_pkg::ADDR_CTRL_ZERO, 8'h18);
        tick(2);
        check_rng(cnt, 10'd0, 10'd3);
        $display("test pause done");
    endtask

    task automatic t_capture();
        logic [9:0] v;
        logic [7:0] l, h;
        logic ex;
        tick(300);
        wr(etc_pkg::ADDR_CTRL_ZERO, 8'h98);
        tick(3);
        v = cnt;
        for (int f = 0; f < 4; f++) begin
            wr(etc_pkg::ADDR_CTRL_ONE, {2'b01, 2'(f), 4'h0});
            wr(etc_pkg::ADDR_CMPA_LO, 8'h00);
            wr(etc_pkg::ADDR_CMPA_HI, 8'h00);
            for (int k = 0; k < 2; k++) begin
                wr(etc_pkg::ADDR_STATUS, 8'h0F);
                pin_flip(2'(f % 3));
                tick(6);
                ex = (f == 2) || (f == k);
                check(10'(cap_f), 10'(ex));
                check(10'(per_f), 10'h000);
                rd(etc_pkg::ADDR_CMPA_LO, l);
                rd(etc_pkg::ADDR_CMPA_HI, h);
                check({h[1:0], l}, (f == 3 || (f == 1 && k == 0)) ? 10'h000 : v);
                check(cnt, v);
            end
        end
        wr(etc_pkg::ADDR_CTRL_ONE, 8'h00);
        $display("test capture done");
    endtask

    task automatic t_clk_sel();
        logic [2:0] sel [4] = '{3'h0, 3'h2, 3'h3, 3'h5};
        int cyc [4] = '{40, 160, 640, 30};
        for (int i = 0; i < 4; i++) begin
            restart(sel[i]);
            tick(cyc[i]);
            check_rng(cnt, (i == 3) ? 10'd0 : 10'd7, (i == 3) ? 10'd0 : 10'd11);
        end
        restart(etc_pkg::CK_TIME_BASE);
        repeat (5) begin
            @(posedge clk);
            tbt <= 1'b1;
            @(posedge clk);
            tbt <= 1'b0;
        end
        tick(2);
        check(cnt, 10'd5);
        restart(etc_pkg::CK_EXT_RISE);
        repeat (6) pin_flip(2'd3);
        tick(5);
        check(cnt, 10'd3);
        restart(etc_pkg::CK_EXT_FALL);
        repeat (6) pin_flip(2'd3);
        tick(5);
        check(cnt, 10'd3);
        $display("test clock select done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        tbt = 1'b0;
        fl = 1'b0;
        which = 2'h0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_period();
        t_pause();
        t_capture();
        t_clk_sel();
        results();
    end
endmodule // enhanced_timer_capture_core_tb_top
`default_nettype wire
